// ===== hw/tap_map.vh
// Constants for the test access port and debug-event logic
// Contract
// [RL1] The device has a standard test access port state machine and test logic clocked by the test clock; the code uses clk and synchronised tck edges.
// [RL2] The serial test data input is captured on each rising test clock edge.
// [RL3] The mode select input is captured on each rising test clock edge and advances the state machine.
// [RL4] The test data output is driven only in shift-IR or shift-DR and floats otherwise, also in reset.
// [RL5] The test data output changes only on falling test clock edges.
// [RL6] The test reset input initialises the state machine without any test clock edge.
// [RL7] The outside controller asserts test reset after power-up.
// [RL8] An asserted debug-event input makes the core finish its instruction, save state, enter debug mode and wait for commands.
// [RL9] On entering debug mode for a request or a breakpoint the device pulls the debug-event pin for three clock cycles.
// [RL10] The device drives the debug-event pin only as an open-drain output.
// [RL11] The debug-event pin goes straight to the emulation logic and everything else passes the serial test port.
// [RL12] The emulation logic lets the outside controller inspect registers, memory and peripherals without disturbing operation.
// [RL13] The debug-event input is synchronised before use and the pin is released after its three-cycle pulse.
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
// ***********************************************
// Instructions and timing
// ***********************************************
`define IR_WIDTH 4
`define IR_RESET 4'h1
`define IR_BYPASS 4'hF
`define IR_IDCODE 4'h1
`define IR_DEBUG 4'h6
`define IDCODE_VALUE 32'h00000001
`define DBG_PULSE_CYCLES 2'h3
`define DBG_WIDTH 24
`endif

// ===== hw/jtag_debug_access_port.v
// Test access port with debug-event pin and emulation data path
`include "tap_map.vh"
`default_nettype none

module jtag_debug_access_port #(
   parameter IDCODE = `IDCODE_VALUE, // Arbitrary identity value
   parameter DW = `DBG_WIDTH
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire trst_n,
   output reg tdo_o,
   output reg tdo_oe_n,
   input wire debug_event_pin_i,
   output reg debug_event_pin_o,
   output reg debug_event_pin_oe_n,
   input wire core_instr_done,
   input wire breakpoint_hit,
   input wire [DW-1:0] core_read_data,
   output reg debug_halt_req,
   output reg debug_mode,
   output reg [DW-1:0] debug_command,
   output reg debug_command_valid
);

// ***********************************************
// Pin synchronisers
// ***********************************************
// Two flip-flops per pin; only the second stage feeds logic
reg [1:0] tck_s_reg;
reg [1:0] tms_s_reg;
reg [1:0] tdi_s_reg;
reg [1:0] trst_s_reg;
reg [1:0] dbg_s_reg;
reg tck_d_reg;

// Capture pins while the clock enable is high
always @(posedge clk) begin
   if (clk_en) begin
      tck_s_reg <= {tck_s_reg[0], tck};
      tms_s_reg <= {tms_s_reg[0], tms};
      tdi_s_reg <= {tdi_s_reg[0], tdi};
      trst_s_reg <= {trst_s_reg[0], trst_n};
      dbg_s_reg <= {dbg_s_reg[0], debug_event_pin_i}; // RL13
      tck_d_reg <= tck_s_reg[1];
   end
end

// Test clock edges, seen a few cycles late; both resets restart the port
wire tck_rise = tck_s_reg[1] & ~tck_d_reg;
wire tck_fall = ~tck_s_reg[1] & tck_d_reg;
wire trst_act = ~trst_s_reg[1];
wire treset = ~rst_n | trst_act;

// ***********************************************
// Controller states
// ***********************************************
// One-hot controller states
localparam [15:0] S_TLR = 16'h0001;
localparam [15:0] S_RTI = 16'h0002;
localparam [15:0] S_SDR = 16'h0004;
localparam [15:0] S_CDR = 16'h0008;
localparam [15:0] S_SHDR = 16'h0010;
localparam [15:0] S_E1DR = 16'h0020;
localparam [15:0] S_PDR = 16'h0040;
localparam [15:0] S_E2DR = 16'h0080;
localparam [15:0] S_UDR = 16'h0100;
localparam [15:0] S_SIR = 16'h0200;
localparam [15:0] S_CIR = 16'h0400;
localparam [15:0] S_SHIR = 16'h0800;
localparam [15:0] S_E1IR = 16'h1000;
localparam [15:0] S_PIR = 16'h2000;
localparam [15:0] S_E2IR = 16'h4000;
localparam [15:0] S_UIR = 16'h8000;
reg [15:0] tap_reg, tap_next;

// Next state from mode select
always @* begin
   tap_next = S_TLR;
   case (tap_reg)
      S_TLR: tap_next = tms_s_reg[1] ? S_TLR : S_RTI;
      S_RTI: tap_next = tms_s_reg[1] ? S_SDR : S_RTI;
      S_SDR: tap_next = tms_s_reg[1] ? S_SIR : S_CDR;
      S_CDR: tap_next = tms_s_reg[1] ? S_E1DR : S_SHDR;
      S_SHDR: tap_next = tms_s_reg[1] ? S_E1DR : S_SHDR;
      S_E1DR: tap_next = tms_s_reg[1] ? S_UDR : S_PDR;
      S_PDR: tap_next = tms_s_reg[1] ? S_E2DR : S_PDR;
      S_E2DR: tap_next = tms_s_reg[1] ? S_UDR : S_SHDR;
      S_UDR: tap_next = tms_s_reg[1] ? S_SDR : S_RTI;
      S_SIR: tap_next = tms_s_reg[1] ? S_TLR : S_CIR;
      S_CIR: tap_next = tms_s_reg[1] ? S_E1IR : S_SHIR;
      S_SHIR: tap_next = tms_s_reg[1] ? S_E1IR : S_SHIR;
      S_E1IR: tap_next = tms_s_reg[1] ? S_UIR : S_PIR;
      S_PIR: tap_next = tms_s_reg[1] ? S_E2IR : S_PIR;
      S_E2IR: tap_next = tms_s_reg[1] ? S_UIR : S_SHIR;
      S_UIR: tap_next = tms_s_reg[1] ? S_SDR : S_RTI;
      default: tap_next = S_TLR;
   endcase
end

// ***********************************************
// Controller and shift registers
// ***********************************************
// Shift paths, instruction and command words
reg [`IR_WIDTH-1:0] ir_sh_reg, ir_reg;
reg [31:0] id_sh_reg;
reg [DW-1:0] dbg_sh_reg;
reg byp_reg;
reg cmd_toggle_reg;
reg [DW-1:0] cmd_word_reg;

// Controller step on each detected rising test clock edge
always @(posedge clk) begin
   if (treset) begin
      tap_reg <= S_TLR; // RL6
      ir_reg <= `IR_RESET;
      ir_sh_reg <= {`IR_WIDTH{1'b0}};
      id_sh_reg <= 32'h00000000;
      dbg_sh_reg <= {DW{1'b0}};
      byp_reg <= 1'b0;
      cmd_toggle_reg <= 1'b0;
      cmd_word_reg <= {DW{1'b0}};
   end else if (clk_en && tck_rise) begin
      tap_reg <= tap_next; // RL1 RL3
      if (tap_reg == S_CIR)
         ir_sh_reg <= `IR_RESET;
      if (tap_reg == S_SHIR)
         ir_sh_reg <= {tdi_s_reg[1], ir_sh_reg[`IR_WIDTH-1:1]}; // RL2
      if (tap_reg == S_UIR)
         ir_reg <= ir_sh_reg;
      if (tap_reg == S_CDR) begin
         id_sh_reg <= IDCODE;
         dbg_sh_reg <= core_read_data; // RL12
         byp_reg <= 1'b0;
      end
      if (tap_reg == S_SHDR) begin
         id_sh_reg <= {tdi_s_reg[1], id_sh_reg[31:1]}; // RL2
         dbg_sh_reg <= {tdi_s_reg[1], dbg_sh_reg[DW-1:1]};
         byp_reg <= tdi_s_reg[1];
      end
      if (tap_reg == S_UDR && ir_reg == `IR_DEBUG) begin
         cmd_word_reg <= dbg_sh_reg; // RL11
         cmd_toggle_reg <= ~cmd_toggle_reg;
      end
   end
end

// Shift state and the data register bit put on the output
wire shifting = (tap_reg == S_SHIR) | (tap_reg == S_SHDR);
wire dr_bit = (ir_reg == `IR_IDCODE) ? id_sh_reg[0] :
   (ir_reg == `IR_DEBUG) ? dbg_sh_reg[0] : byp_reg;

// Serial output on the falling edge
always @(posedge clk) begin
   if (treset) begin
      tdo_o <= 1'b0;
      tdo_oe_n <= 1'b1; // RL4
   end else if (clk_en && tck_fall) begin
      tdo_o <= (tap_reg == S_SHIR) ? ir_sh_reg[0] : dr_bit; // RL5
      tdo_oe_n <= ~shifting; // RL4
   end
end

// ***********************************************
// Debug-event handling
// ***********************************************
// One-hot sequencer states
localparam [2:0] D_RUN = 3'h1;
localparam [2:0] D_HALT = 3'h2;
localparam [2:0] D_DBG = 3'h4;

// Sequencer, acknowledge counter and pin history
reg [2:0] dst_reg;
reg [1:0] pulse_reg;
reg dbg_d_reg;
reg cmd_t_d_reg;
// History resets to the idle high level, so reset gives no false request
wire req_fall = ~dbg_s_reg[1] & dbg_d_reg;

// Halt request, debug entry, acknowledge pulse and command hand-over
always @(posedge clk) begin
   if (!rst_n) begin
      dst_reg <= D_RUN;
      pulse_reg <= 2'h0;
      dbg_d_reg <= 1'b1;
      cmd_t_d_reg <= 1'b0;
      debug_halt_req <= 1'b0;
      debug_mode <= 1'b0;
      debug_event_pin_o <= 1'b0;
      debug_event_pin_oe_n <= 1'b1;
      debug_command <= {DW{1'b0}};
      debug_command_valid <= 1'b0;
   end else if (clk_en) begin
      dbg_d_reg <= dbg_s_reg[1];
      cmd_t_d_reg <= cmd_toggle_reg;
      debug_command_valid <= 1'b0;
      if (pulse_reg != 2'h0)
         pulse_reg <= pulse_reg - 2'h1;
      debug_event_pin_oe_n <= ~(pulse_reg != 2'h0); // RL9 RL10 RL13
      case (dst_reg)
         D_RUN: begin
            if (breakpoint_hit) begin
               dst_reg <= D_DBG;
               debug_mode <= 1'b1;
               pulse_reg <= `DBG_PULSE_CYCLES; // RL9
            end else if (req_fall) begin
               dst_reg <= D_HALT;
               debug_halt_req <= 1'b1; // RL8
            end
         end
         D_HALT: begin
            // A breakpoint while waiting enters debug mode as well
            if (core_instr_done || breakpoint_hit) begin
               dst_reg <= D_DBG;
               debug_halt_req <= 1'b0;
               debug_mode <= 1'b1; // RL8
               pulse_reg <= `DBG_PULSE_CYCLES; // RL9
            end
         end
         D_DBG: begin
            if (cmd_toggle_reg != cmd_t_d_reg) begin
               debug_command <= cmd_word_reg; // RL8 RL11
               debug_command_valid <= 1'b1;
            end
         end
         default: dst_reg <= D_RUN;
      endcase
   end
end

endmodule // jtag_debug_access_port
`default_nettype wire

// ===== testbench/tap_checker_assertions.sv
// Checker of the debug access port pin behaviour
`default_nettype none
module tap_checker (
   input wire clk,
   input wire rst_n,
   input wire tck,
   input wire trst_n,
   input wire tdo_o,
   input wire tdo_oe_n,
   input wire debug_event_pin_i,
   input wire debug_event_pin_o,
   input wire debug_event_pin_oe_n,
   input wire core_instr_done,
   input wire breakpoint_hit,
   input wire debug_halt_req,
   input wire debug_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_tdo_float: assert property (!trst_n [*6] |-> tdo_oe_n)
      else $error("test out driven");
   a_tdo_fall: assert property ($changed(tdo_o) && !tdo_oe_n |-> !tck)
      else $error("test out late");
   a_ack_len: assert property ($fell(debug_event_pin_oe_n)
      |-> !debug_event_pin_oe_n [*3] ##1 debug_event_pin_oe_n) else $error("ack");
   a_open_drain: assert property (!debug_event_pin_oe_n
      |-> !debug_event_pin_o) else $error("pin high");
   a_ack_start: assert property ($rose(debug_mode)
      |=> $fell(debug_event_pin_oe_n)) else $error("no ack");
   a_req_halt: assert property ($fell(debug_event_pin_i) && !debug_mode
      && !debug_halt_req |-> ##[1:5] debug_halt_req) else $error("no halt");
   a_halt_entry: assert property (debug_halt_req && core_instr_done
      |=> debug_mode) else $error("no entry");
   a_break_entry: assert property (breakpoint_hit |=> debug_mode)
      else $error("no break");
endmodule // tap_checker
bind jtag_debug_access_port tap_checker i_tap_checker (.*);
`default_nettype wire

// ===== testbench/jtag_ctrl.sv
// Model of the outside test and debug controller
`default_nettype none
module jtag_ctrl (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {tck, tms, tdi, trst_n} = 4'h6;
   // One 160 ns clock period, lines moved while clock low
   task automatic step(input logic m, d, output logic q);
      {tms, tdi} = {m, d};
      #80 q = tdo;
      tck = 1'b1;
      #80 tck = 1'b0;
   endtask
   // Shift n bits with a mode select string, clock still after
   task automatic shift(input logic [31:0] s, v, input int n,
      output logic [31:0] r);
      for (int i = 0; i < n; i++) step(s[i], v[i], r[i]);
   endtask
   // Test reset pulse with the clock stopped
   task automatic hold_reset;
      trst_n = 1'b0;
      #100 trst_n = 1'b1;
      #50;
   endtask
endmodule // jtag_ctrl
`default_nettype wire

// ===== testbench/tb.sv
// Bench of the debug access port against a controller model
`include "tap_map.vh"
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
   fail_count++; $display("ERROR %0t mismatch", $time); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, de_req = 1'b0, done = 1'b0, bp = 1'b0;
   logic [23:0] got;
   logic [31:0] r;
   int fail_count = 0, compares = 0, cyc = 0, n;
   wire tck, tms, tdi, trst_n, tdo_o, tdo_oe_n, de_o, de_oe_n, halt, mode;
   wire cmd_v;
   wire [23:0] cmd;
   // Pulled-up event line; released test output shows the inverse
   wire de_w = ~((~de_oe_n & ~de_o) | de_req);
   wire tdo_w = tdo_oe_n ? ~tdo_o : tdo_o;
   always #5 clk = ~clk;
   always @(posedge clk) if (cmd_v === 1'b1) got <= cmd;
   jtag_ctrl i_jtag_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo(tdo_w));
   jtag_debug_access_port i_jtag_debug_access_port (.clk(clk), .rst_n(rst_n),
      .clk_en(1'b1), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .debug_event_pin_i(de_w),
      .debug_event_pin_o(de_o), .debug_event_pin_oe_n(de_oe_n),
      .core_instr_done(done), .breakpoint_hit(bp), .core_read_data(24'hA5C396),
      .debug_halt_req(halt), .debug_mode(mode), .debug_command(cmd),
      .debug_command_valid(cmd_v));
   // Pulse a core input, count low cycles of the event line
   task automatic pulse_count(ref logic s);
      n = 0;
      @(posedge clk) #1 s = 1'b1;
      repeat (10) begin
         @(posedge clk) #1 s = 1'b0;
         n += !de_w;
      end
   endtask
   // Outside debug request held five cycles
   task automatic request;
      @(posedge clk) #1 de_req = 1'b1;
      repeat (5) @(posedge clk);
      #1 de_req = 1'b0;
   endtask
   // Load an instruction, check the captured pattern, end in shift-DR
   task automatic ir(input logic [31:0] v);
      i_jtag_ctrl.shift(32'h3, 32'hF, 4, r);
      i_jtag_ctrl.shift(32'h8, v, 4, r);
      `CHK(r[3:0], `IR_RESET)
      i_jtag_ctrl.shift(32'h5, 32'hF, 5, r);
   endtask
   task automatic t_idcode;
      i_jtag_ctrl.shift(32'h2, 32'hF, 4, r);
      #50; // Enable follows the detected falling edge
      `CHK(tdo_oe_n, 1'b0)
      i_jtag_ctrl.shift(32'h80000000, 32'h0, 32, r);
      `CHK(r, `IDCODE_VALUE)
      i_jtag_ctrl.shift(32'h1, 32'hF, 2, r);
      `CHK(tdo_oe_n, 1'b1)
   endtask
   task automatic t_bypass;
      ir(32'hF);
      i_jtag_ctrl.shift(32'h80, 32'hB4, 8, r);
      `CHK(r[7:0], 8'h68)
      i_jtag_ctrl.shift(32'h2, 32'hF, 3, r);
      #50; // Enable follows the detected falling edge
      `CHK(tdo_oe_n, 1'b0)
      i_jtag_ctrl.hold_reset();
      `CHK(tdo_oe_n, 1'b1)
   endtask
   task automatic t_debug;
      request();
      `CHK({halt, mode}, 2'h2)
      pulse_count(done);
      `CHK(n, 3)
      `CHK(mode, 1'b1)
      request();
      `CHK(halt, 1'b0)
   endtask
   task automatic t_command;
      ir(32'h6);
      i_jtag_ctrl.shift(32'h800000, 32'h3C5A69, 24, r);
      `CHK(r[23:0], 24'hA5C396)
      i_jtag_ctrl.shift(32'h1, 32'hF, 2, r);
      `CHK(got, 24'h3C5A69)
   endtask
   task automatic t_break;
      @(posedge clk) #1 rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      `CHK(mode, 1'b0)
      pulse_count(bp);
      `CHK(n, 3)
   endtask
   task automatic end_of_test;
      $display("Compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Cycle ceiling far above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      i_jtag_ctrl.hold_reset();
      t_idcode();
      t_bypass();
      t_idcode();
      t_debug();
      t_command();
      t_break();
      end_of_test();
   end
endmodule // tb
`default_nettype wire
